// ==== efti_pkg.sv ====
`default_nettype none
package efti_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_NS = 40;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC_DEF = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TW = 16;
  localparam int DW = 10;
  localparam logic [DW-1:0] BFU_MIN_MS = 10'h064;
  localparam logic [DW-1:0] BFU_MAX_MS = 10'h3E8;
  localparam logic [TW-1:0] OP_MIN_TICKS = 16'h0001;
  // ************************************************************
  // stage indices
  // ************************************************************
  localparam int ST_LS_OC = 0;
  localparam int ST_HS_OC = 1;
  localparam int ST_LS_EF = 2;
  localparam int ST_HS_EF = 3;
  localparam int NST = 4;
  // ************************************************************
  // switch positions (switch n sits at index n-1)
  // ************************************************************
  localparam int SPC_BLOCK_LO = 0;
  localparam int SPC_OC_LATCH = 5;
  localparam int SPC_EF_LATCH = 6;
  localparam int SPC_EXT_BANK = 7;
  localparam int FN1_OC_CURVE_LO = 0;
  localparam int FN1_BFU_EN = 3;
  localparam int FN1_EF_CURVE_LO = 5;
  localparam int FN2_MANUAL_LO = 0;
  localparam int FN2_HS_OC_OFF = 4;
  localparam int FN2_HS_EF_OFF = 5;
  localparam int SGR_HI_LO = 4;
  localparam int RT3_BFU = 4;
  // ************************************************************
  // display codes
  // ************************************************************
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_BFU = 4'h9;
  localparam logic [3:0] FAULT_RED_ONE = 4'h1;
  typedef enum logic [2:0] {
    BF_IDLE = 3'h1,
    BF_TIMING = 3'h2,
    BF_TRIPPED = 3'h4
  } efti_bf_t;
endpackage
`default_nettype wire

// ==== efti_tick.sv ====
`timescale 1ns/100ps
`default_nettype none
module efti_tick #(
  parameter int TICK_CYC = 25000
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  localparam int CW = $clog2(TICK_CYC + 1);
  logic [CW-1:0] cnt_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r == CW'(TICK_CYC - 1));
      cnt_r <= (cnt_r == CW'(TICK_CYC - 1)) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule // efti_tick
`default_nettype wire

// ==== efti_stage.sv ====
`timescale 1ns/100ps
`default_nettype none
module efti_stage
  import efti_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic exceed,
  input wire logic block,
  input wire logic inhibit,
  input wire logic [TW-1:0] op_ticks,
  output logic started,
  output logic operated
);
  logic [TW-1:0] cnt_r;
  logic [TW-1:0] lim;
  assign lim = (op_ticks < OP_MIN_TICKS) ? OP_MIN_TICKS : op_ticks;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      started <= 1'b0;
    end else begin
      started <= exceed & ~block;
    end
  end
  // the operate timer restarts whenever the stage drops or is inhibited
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      operated <= 1'b0;
    end else begin
      if (!started || inhibit) begin
        cnt_r <= '0;
      end else if (tick && cnt_r != lim) begin
        cnt_r <= cnt_r + 1'b1;
      end
      operated <= started & ~inhibit & (cnt_r >= lim);
    end
  end
endmodule // efti_stage
`default_nettype wire

// ==== efti_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - inverse low-set inhibited while high-set started
// - special switches six and seven latch main trip
// - latch cleared by both buttons or command
// - second group switch six disables high-set earth
// - breaker failure re-trips after set delay
// - first group switch four enables breaker failure
// - two setting banks, three selection sources
// - one shared trip lamp for all stages
// - trip indications held until reset button
// - indicators never influence protection behaviour
// - start indication self-clears unless manual reset
// - display digits one to nine encode events
// - phase indicators latch on operation
// - internal fault lights alarm and relay
// - fault code shows red one, green number
// - three routing groups steer the outputs
// - stage starts over threshold, operates after time
// - external input blocks stages chosen by switches
module efti_top
  import efti_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [2:0] LS_OC_EXCEED,
  input wire logic [2:0] HS_OC_EXCEED,
  input wire logic LS_EF_EXCEED,
  input wire logic HS_EF_EXCEED,
  input wire logic [TW-1:0] LS_OC_OP_TICKS,
  input wire logic [TW-1:0] HS_OC_OP_TICKS,
  input wire logic [TW-1:0] LS_EF_OP_TICKS,
  input wire logic [TW-1:0] HS_EF_OP_TICKS,
  input wire logic [DW-1:0] BFU_DELAY_MS,
  input wire logic EXTERNAL_CONTROL_INPUT,
  input wire logic BTN_RESET,
  input wire logic BTN_PROGRAM,
  input wire logic LATCH_CLEAR_COMMAND,
  input wire logic BANK_SELECT_COMMAND,
  input wire logic BANK_SELECT_VALUE,
  input wire logic MENU_BANK_WRITE,
  input wire logic MENU_BANK_VALUE,
  input wire logic [7:0] SPECIAL_SWITCH_GROUP,
  input wire logic [7:0] FUNCTION_SWITCH_GROUP_ONE,
  input wire logic [7:0] FUNCTION_SWITCH_GROUP_TWO,
  input wire logic [7:0] OUTPUT_ROUTE_GROUP_ONE,
  input wire logic [7:0] OUTPUT_ROUTE_GROUP_TWO,
  input wire logic [7:0] OUTPUT_ROUTE_GROUP_THREE,
  input wire logic SELF_FAULT,
  input wire logic [3:0] SELF_FAULT_CODE,
  output logic START_OUTPUT,
  output logic MAIN_TRIP_OUTPUT,
  output logic TRIP_OUTPUT_ONE,
  output logic TRIP_OUTPUT_TWO,
  output logic AUX_TRIP_OUTPUT,
  output logic TRIP_LAMP,
  output logic [3:0] PHASE_IND,
  output logic [3:0] DISP_CODE,
  output logic HS_OC_DASHES,
  output logic HS_EF_DASHES,
  output logic SECOND_BANK_ACTIVE,
  output logic INTERNAL_FAULT_ALARM_LAMP,
  output logic INTERNAL_FAULT_RELAY,
  output logic [3:0] FAULT_RED_DIGIT,
  output logic [3:0] FAULT_GREEN_CODE
);
  // ************************************************************
  // pin synchronisers and button edges
  // ************************************************************
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [1:0] btn_d_r;
  logic ext_d_r;
  logic ext_s, rst_btn, prg_btn, flt_s;
  logic rst_press, both_press;
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      meta_r <= '0;
      sync_r <= '0;
      btn_d_r <= '0;
      ext_d_r <= 1'b0;
    end else begin
      meta_r <= {SELF_FAULT, BTN_PROGRAM, BTN_RESET, EXTERNAL_CONTROL_INPUT};
      sync_r <= meta_r;
      btn_d_r <= sync_r[2:1];
      ext_d_r <= sync_r[0];
    end
  end
  assign ext_s = sync_r[0];
  assign rst_btn = sync_r[1];
  assign prg_btn = sync_r[2];
  assign flt_s = sync_r[3];
  // the reset button acts once per press, not for as long as it is held
  assign rst_press = rst_btn & ~btn_d_r[0];
  // both held, with either of them the later one to go down
  assign both_press = rst_btn & prg_btn & ~(btn_d_r[0] & btn_d_r[1]);

  // ************************************************************
  // time base and protection stages
  // ************************************************************
  logic tick;
  efti_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .tick(tick)
  );

  logic [NST-1:0] exceed, block, inhibit, started, operated;
  logic [NST-1:0][TW-1:0] op_ticks;
  logic oc_inverse, ef_inverse;
  assign oc_inverse = |FUNCTION_SWITCH_GROUP_ONE[FN1_OC_CURVE_LO +: 3];
  assign ef_inverse = |FUNCTION_SWITCH_GROUP_ONE[FN1_EF_CURVE_LO +: 3];
  assign exceed[ST_LS_OC] = |LS_OC_EXCEED;
  assign exceed[ST_HS_OC] = |HS_OC_EXCEED & ~FUNCTION_SWITCH_GROUP_TWO[FN2_HS_OC_OFF];
  assign exceed[ST_LS_EF] = LS_EF_EXCEED;
  // a disabled high-set earth stage behaves as if its threshold were infinite
  assign exceed[ST_HS_EF] = HS_EF_EXCEED & ~FUNCTION_SWITCH_GROUP_TWO[FN2_HS_EF_OFF];
  assign block = {NST{ext_s}} & SPECIAL_SWITCH_GROUP[SPC_BLOCK_LO +: NST];
  assign inhibit[ST_LS_OC] = oc_inverse & started[ST_HS_OC];
  assign inhibit[ST_LS_EF] = ef_inverse & started[ST_HS_EF];
  assign inhibit[ST_HS_OC] = 1'b0;
  assign inhibit[ST_HS_EF] = 1'b0;
  assign op_ticks[ST_LS_OC] = LS_OC_OP_TICKS;
  assign op_ticks[ST_HS_OC] = HS_OC_OP_TICKS;
  assign op_ticks[ST_LS_EF] = LS_EF_OP_TICKS;
  assign op_ticks[ST_HS_EF] = HS_EF_OP_TICKS;

  for (genvar k = 0; k < NST; k++) begin : g_stage
    efti_stage u_stage (
      .clk(SYS_CLK),
      .rst_n(RSTN),
      .tick(tick),
      .exceed(exceed[k]),
      .block(block[k]),
      .inhibit(inhibit[k]),
      .op_ticks(op_ticks[k]),
      .started(started[k]),
      .operated(operated[k])
    );
  end

  // ************************************************************
  // main trip, latch and routed outputs
  // ************************************************************
  logic [NST-1:0] main_route, latch_en;
  logic latch_r, latch_set, latch_clr, main_d_r, bfu_trip;
  assign main_route = operated & OUTPUT_ROUTE_GROUP_ONE[SGR_HI_LO +: NST];
  assign latch_en = {{2{SPECIAL_SWITCH_GROUP[SPC_EF_LATCH]}}, {2{SPECIAL_SWITCH_GROUP[SPC_OC_LATCH]}}};
  assign latch_set = |(main_route & latch_en);
  assign latch_clr = both_press | LATCH_CLEAR_COMMAND;
  // only indicator-independent signals feed the trip path
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      latch_r <= 1'b0;
    end else if (latch_set) begin
      latch_r <= 1'b1;
    end else if (latch_clr) begin
      latch_r <= 1'b0;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      START_OUTPUT <= 1'b0;
      MAIN_TRIP_OUTPUT <= 1'b0;
      TRIP_OUTPUT_ONE <= 1'b0;
      TRIP_OUTPUT_TWO <= 1'b0;
      AUX_TRIP_OUTPUT <= 1'b0;
      main_d_r <= 1'b0;
    end else begin
      START_OUTPUT <= |(started & OUTPUT_ROUTE_GROUP_ONE[NST-1:0]);
      MAIN_TRIP_OUTPUT <= (|main_route) | latch_r;
      TRIP_OUTPUT_ONE <= |(operated & OUTPUT_ROUTE_GROUP_TWO[NST-1:0]);
      TRIP_OUTPUT_TWO <= |(operated & OUTPUT_ROUTE_GROUP_TWO[SGR_HI_LO +: NST]);
      AUX_TRIP_OUTPUT <= |(started & OUTPUT_ROUTE_GROUP_THREE[NST-1:0])
                         | (bfu_trip & OUTPUT_ROUTE_GROUP_THREE[RT3_BFU]);
      main_d_r <= MAIN_TRIP_OUTPUT;
    end
  end

  // ************************************************************
  // breaker failure re-trip
  // ************************************************************
  efti_bf_t bf_r;
  logic [DW-1:0] bf_cnt_r, bf_lim;
  logic bf_en, fault_on;
  assign bf_en = FUNCTION_SWITCH_GROUP_ONE[FN1_BFU_EN];
  assign fault_on = |started;
  assign bf_lim = (BFU_DELAY_MS < BFU_MIN_MS) ? BFU_MIN_MS :
                  (BFU_DELAY_MS > BFU_MAX_MS) ? BFU_MAX_MS : BFU_DELAY_MS;
  assign bfu_trip = (bf_r == BF_TRIPPED);
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      bf_r <= BF_IDLE;
      bf_cnt_r <= '0;
    end else begin
      case (bf_r)
        BF_IDLE: begin
          bf_cnt_r <= '0;
          if (bf_en && MAIN_TRIP_OUTPUT && !main_d_r) begin
            bf_r <= BF_TIMING;
          end
        end
        BF_TIMING: begin
          if (!bf_en || !fault_on) begin
            bf_r <= BF_IDLE;
          end else if (bf_cnt_r >= bf_lim) begin
            bf_r <= BF_TRIPPED;
          end else if (tick) begin
            bf_cnt_r <= bf_cnt_r + 1'b1;
          end
        end
        BF_TRIPPED: begin
          if (!bf_en || !fault_on) begin
            bf_r <= BF_IDLE;
          end
        end
        default: bf_r <= BF_IDLE;
      endcase
    end
  end

  // ************************************************************
  // setting bank
  // ************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      SECOND_BANK_ACTIVE <= 1'b0;
    end else if (BANK_SELECT_COMMAND) begin
      SECOND_BANK_ACTIVE <= BANK_SELECT_VALUE;
    end else if (MENU_BANK_WRITE) begin
      SECOND_BANK_ACTIVE <= MENU_BANK_VALUE;
    end else if (SPECIAL_SWITCH_GROUP[SPC_EXT_BANK] && (ext_s != ext_d_r)) begin
      SECOND_BANK_ACTIVE <= ext_s;
    end
  end

  // ************************************************************
  // indicator memory and display
  // ************************************************************
  logic [NST-1:0] st_ind_r, op_ind_r, manual;
  logic bf_ind_r;
  logic [3:0] ph_set;
  logic [3:0] code_nxt;
  assign manual = FUNCTION_SWITCH_GROUP_TWO[FN2_MANUAL_LO +: NST];
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      st_ind_r <= '0;
      op_ind_r <= '0;
      bf_ind_r <= 1'b0;
    end else begin
      // set wins over the button so a new event is never lost
      st_ind_r <= started | (st_ind_r & ~{NST{rst_press}} & manual);
      op_ind_r <= operated | (op_ind_r & ~{NST{rst_press}});
      bf_ind_r <= bfu_trip | (bf_ind_r & ~rst_press);
    end
  end
  assign TRIP_LAMP = (|op_ind_r) | bf_ind_r;
  assign ph_set = {operated[ST_LS_EF] | operated[ST_HS_EF],
                   ({3{operated[ST_LS_OC]}} & LS_OC_EXCEED) | ({3{operated[ST_HS_OC]}} & HS_OC_EXCEED)};
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      PHASE_IND <= '0;
    end else begin
      PHASE_IND <= ph_set | (PHASE_IND & ~{4{rst_press}});
    end
  end
  // highest digit wins when several events are remembered at once
  always_comb begin
    code_nxt = CODE_NONE;
    for (int k = 0; k < NST; k++) begin
      if (st_ind_r[k]) begin
        code_nxt = 4'(2 * k + 1);
      end
      if (op_ind_r[k]) begin
        code_nxt = 4'(2 * k + 2);
      end
    end
    if (bf_ind_r) begin
      code_nxt = CODE_BFU;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      DISP_CODE <= CODE_NONE;
      HS_OC_DASHES <= 1'b0;
      HS_EF_DASHES <= 1'b0;
    end else begin
      DISP_CODE <= code_nxt;
      HS_OC_DASHES <= FUNCTION_SWITCH_GROUP_TWO[FN2_HS_OC_OFF];
      HS_EF_DASHES <= FUNCTION_SWITCH_GROUP_TWO[FN2_HS_EF_OFF];
    end
  end

  // ************************************************************
  // self-supervision
  // ************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      INTERNAL_FAULT_ALARM_LAMP <= 1'b0;
      INTERNAL_FAULT_RELAY <= 1'b0;
      FAULT_RED_DIGIT <= CODE_NONE;
      FAULT_GREEN_CODE <= CODE_NONE;
    end else begin
      INTERNAL_FAULT_ALARM_LAMP <= flt_s;
      INTERNAL_FAULT_RELAY <= flt_s;
      // faults without a diagnostic code leave the code digits dark
      if (flt_s && SELF_FAULT_CODE != CODE_NONE) begin
        FAULT_RED_DIGIT <= FAULT_RED_ONE;
        FAULT_GREEN_CODE <= SELF_FAULT_CODE;
      end else begin
        FAULT_RED_DIGIT <= CODE_NONE;
        FAULT_GREEN_CODE <= CODE_NONE;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_inverse_inhibit: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    ef_inverse && started[ST_HS_EF] |=> !operated[ST_LS_EF]) else $error("low-set earth operated while inhibited");
  a_latch_hold: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    latch_set ##1 !latch_clr [*2] |=> MAIN_TRIP_OUTPUT) else $error("latched main trip dropped");
  a_latch_clear: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    latch_clr && !latch_set |=> !latch_r) else $error("latch not cleared");
  a_hs_ef_off: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    FUNCTION_SWITCH_GROUP_TWO[FN2_HS_EF_OFF] [*3] |-> !started[ST_HS_EF] && !operated[ST_HS_EF])
    else $error("disabled high-set earth stage active");
  a_bfu_off: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    !bf_en |=> bf_r == BF_IDLE) else $error("breaker failure ran while disabled");
  a_bfu_abort: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    bf_r == BF_TIMING && !fault_on |=> bf_r == BF_IDLE ##1 (bf_cnt_r == '0 && !bfu_trip))
    else $error("breaker failure not aborted");
  a_bfu_aux: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    bfu_trip && OUTPUT_ROUTE_GROUP_THREE[RT3_BFU] |=> AUX_TRIP_OUTPUT) else $error("aux trip missing");
  a_trip_lamp: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    |operated |=> TRIP_LAMP) else $error("trip lamp not lit");
  a_ind_hold: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    !rst_press |=> (op_ind_r & $past(op_ind_r)) == $past(op_ind_r)) else $error("indication lost");
  a_start_selfclr: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    st_ind_r[0] && !started[0] && !manual[0] |=> !st_ind_r[0]) else $error("start indication kept");
  a_fault_alarm: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    $rose(flt_s) |=> INTERNAL_FAULT_ALARM_LAMP && INTERNAL_FAULT_RELAY) else $error("internal fault not signalled");
endmodule // efti_top
`default_nettype wire

// ==== efti_far.sv ====
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// far side: push-buttons and serial command port
// ************************************************************
module efti_far #(
  parameter int HOLD = 6
) (
  input wire logic clk,
  output logic btn_reset,
  output logic btn_program,
  output logic clr_cmd,
  output logic bank_cmd,
  output logic bank_val,
  output logic menu_wr,
  output logic menu_val
);
  initial begin
    btn_reset = 1'b0;
    btn_program = 1'b0;
    clr_cmd = 1'b0;
    bank_cmd = 1'b0;
    bank_val = 1'b0;
    menu_wr = 1'b0;
    menu_val = 1'b0;
  end
  // a press is held long enough to pass the input synchronisers
  task automatic press(input logic r, input logic p);
    @(negedge clk);
    btn_reset = r;
    btn_program = p;
    repeat (HOLD) @(negedge clk);
    btn_reset = 1'b0;
    btn_program = 1'b0;
  endtask
  // w: 0 latch clear, 1 bank select, 2 menu write; one-cycle pulse
  task automatic pulse(input int w, input logic v);
    @(negedge clk);
    case (w)
      0: clr_cmd = 1'b1;
      1: begin
        bank_cmd = 1'b1;
        bank_val = v;
      end
      default: begin
        menu_wr = 1'b1;
        menu_val = v;
      end
    endcase
    @(negedge clk);
    clr_cmd = 1'b0;
    bank_cmd = 1'b0;
    menu_wr = 1'b0;
    // value no longer qualified, so it must not be trusted
    bank_val = ~v;
    menu_val = ~v;
  endtask
endmodule // efti_far
`default_nettype wire

// ==== efti_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module efti_top_tb;
  // ************************************************************
  // bench
  // ************************************************************
  logic clk = 1'b0;
  logic rstn, ext, sf, lef, hef;
  logic [2:0] loc, hoc;
  logic [15:0] lt, ht;
  logic [9:0] bfd;
  logic [7:0] special_switch_group, sg1, sg2, r1, r2, r3;
  logic [3:0] sfc, ph, disp, red, grn;
  logic st, mt, t1, t2, at, lamp, dsh_oc, dsh_ef, bank2, alm, rly;
  logic br, bp, cc, bc, bv, mw, mv;
  int errors = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  efti_far i_far (.clk(clk), .btn_reset(br), .btn_program(bp), .clr_cmd(cc), .bank_cmd(bc),
    .bank_val(bv), .menu_wr(mw), .menu_val(mv));
  efti_top #(.TICK_CYC(4)) i_dut (.SYS_CLK(clk), .RSTN(rstn), .LS_OC_EXCEED(loc), .HS_OC_EXCEED(hoc),
    .LS_EF_EXCEED(lef), .HS_EF_EXCEED(hef), .LS_OC_OP_TICKS(lt), .HS_OC_OP_TICKS(ht),
    .LS_EF_OP_TICKS(lt), .HS_EF_OP_TICKS(ht), .BFU_DELAY_MS(bfd), .EXTERNAL_CONTROL_INPUT(ext),
    .BTN_RESET(br), .BTN_PROGRAM(bp), .LATCH_CLEAR_COMMAND(cc), .BANK_SELECT_COMMAND(bc),
    .BANK_SELECT_VALUE(bv), .MENU_BANK_WRITE(mw), .MENU_BANK_VALUE(mv), .SPECIAL_SWITCH_GROUP(special_switch_group),
    .FUNCTION_SWITCH_GROUP_ONE(sg1), .FUNCTION_SWITCH_GROUP_TWO(sg2), .OUTPUT_ROUTE_GROUP_ONE(r1),
    .OUTPUT_ROUTE_GROUP_TWO(r2), .OUTPUT_ROUTE_GROUP_THREE(r3), .SELF_FAULT(sf),
    .SELF_FAULT_CODE(sfc), .START_OUTPUT(st), .MAIN_TRIP_OUTPUT(mt), .TRIP_OUTPUT_ONE(t1),
    .TRIP_OUTPUT_TWO(t2), .AUX_TRIP_OUTPUT(at), .TRIP_LAMP(lamp), .PHASE_IND(ph), .DISP_CODE(disp),
    .HS_OC_DASHES(dsh_oc), .HS_EF_DASHES(dsh_ef), .SECOND_BANK_ACTIVE(bank2),
    .INTERNAL_FAULT_ALARM_LAMP(alm), .INTERNAL_FAULT_RELAY(rly), .FAULT_RED_DIGIT(red),
    .FAULT_GREEN_CODE(grn));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // b: 0 main trip, 1 aux trip; bounded wait
  task automatic wt(input int b, input int n);
    while ((b == 0 ? mt : at) !== 1'b1 && n > 0) begin
      cyc(1);
      n--;
    end
  endtask
  task automatic clr_ind();
    i_far.press(1'b1, 1'b0);
    cyc(4);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // longest path is two breaker-failure waits of a few hundred cycles each
  initial begin
    #(40 * 30000);
    errors++;
    finish_test();
  end
  initial begin
    rstn = 1'b0;
    ext = 1'b0;
    sf = 1'b0;
    lef = 1'b0;
    hef = 1'b0;
    loc = 3'h0;
    hoc = 3'h0;
    lt = 16'h0002;
    ht = 16'h0064;
    bfd = 10'h064;
    special_switch_group = 8'h00;
    sg1 = 8'h08;
    sg2 = 8'h00;
    r1 = 8'hFF;
    r2 = 8'h41;
    r3 = 8'h10;
    sfc = 4'h0;
    cyc(4);
    rstn = 1'b1;
    cyc(2);
    for (int c = 0; c < 2; c++) begin
      if (c == 0)
        loc = 3'h3;
      else
        lef = 1'b1;
      cyc(4);
      `CHK("start out", 1'b1, st)
      `CHK("start digit", c ? 4'h5 : 4'h1, disp)
      wt(0, 40);
      cyc(2);
      `CHK("lamp", 1'b1, lamp)
      `CHK("trip digit", c ? 4'h6 : 4'h2, disp)
      `CHK("phase ind", c ? 4'h8 : 4'h3, ph)
      `CHK("trip one", c ? 1'b0 : 1'b1, t1)
      `CHK("trip two", c ? 1'b1 : 1'b0, t2)
      loc = 3'h0;
      lef = 1'b0;
      cyc(3);
      `CHK("main drop", 1'b0, mt)
      `CHK("held digit", c ? 4'h6 : 4'h2, disp)
      cyc(500);
      `CHK("bf abort", 1'b0, at)
      `CHK("held lamp", 1'b1, lamp)
      clr_ind();
      `CHK("lamp clear", 1'b0, lamp)
      `CHK("phase clear", 4'h0, ph)
    end
    done("trip and indication");
    for (int e = 1; e >= 0; e--) begin
      sg1 = e ? 8'h08 : 8'h00;
      lef = 1'b1;
      wt(0, 40);
      cyc(380);
      `CHK("bf early", 1'b0, at)
      wt(1, 60);
      cyc(2);
      `CHK("bf trip", e ? 1'b1 : 1'b0, at)
      `CHK("bf digit", e ? 4'h9 : 4'h6, disp)
      lef = 1'b0;
      cyc(3);
      clr_ind();
    end
    done("breaker failure");
    for (int m = 0; m < 2; m++) begin
      special_switch_group = m ? 8'h20 : 8'h40;
      if (m == 0)
        lef = 1'b1;
      else
        loc = 3'h1;
      wt(0, 40);
      lef = 1'b0;
      loc = 3'h0;
      cyc(20);
      `CHK("latched", 1'b1, mt)
      if (m == 0) begin
        i_far.press(1'b1, 1'b0);
        cyc(4);
        `CHK("reset only", 1'b1, mt)
        i_far.pulse(0, 1'b1);
      end else begin
        i_far.press(1'b1, 1'b1);
      end
      cyc(6);
      `CHK("unlatched", 1'b0, mt)
    end
    special_switch_group = 8'h00;
    clr_ind();
    done("trip latch");
    sg2 = 8'h20;
    hef = 1'b1;
    cyc(30);
    `CHK("ef dashes", 1'b1, dsh_ef)
    `CHK("oc dashes", 1'b0, dsh_oc)
    `CHK("hs off start", 1'b0, st)
    hef = 1'b0;
    sg2 = 8'h10;
    hoc = 3'h4;
    cyc(30);
    `CHK("oc dashes on", 1'b1, dsh_oc)
    `CHK("hs oc off start", 1'b0, st)
    hoc = 3'h0;
    lt = 16'h0064;
    for (int k = 0; k < 2; k++) begin
      sg2 = k ? 8'h04 : 8'h00;
      lef = 1'b1;
      cyc(5);
      lef = 1'b0;
      cyc(5);
      `CHK("short start", k ? 4'h5 : 4'h0, disp)
      clr_ind();
    end
    sg2 = 8'h00;
    lt = 16'h0002;
    done("high-set off and start reset");
    sg1 = 8'h21;
    loc = 3'h1;
    hoc = 3'h1;
    lef = 1'b1;
    hef = 1'b1;
    cyc(40);
    `CHK("inverse held", 1'b0, mt)
    `CHK("hs start digit", 4'h7, disp)
    hef = 1'b0;
    wt(0, 40);
    `CHK("inverse trips", 1'b1, mt)
    `CHK("inverse oc held", 4'h8, ph)
    lef = 1'b0;
    loc = 3'h0;
    hoc = 3'h0;
    sg1 = 8'h00;
    cyc(3);
    clr_ind();
    done("inverse inhibit");
    i_far.pulse(1, 1'b1);
    cyc(2);
    `CHK("bank cmd", 1'b1, bank2)
    i_far.pulse(2, 1'b0);
    cyc(2);
    `CHK("bank menu", 1'b0, bank2)
    special_switch_group = 8'h84;
    ext = 1'b1;
    cyc(6);
    `CHK("bank ext", 1'b1, bank2)
    lef = 1'b1;
    cyc(30);
    `CHK("blocked", 1'b0, st)
    `CHK("blocked trip", 1'b0, mt)
    lef = 1'b0;
    cyc(2);
    ext = 1'b0;
    special_switch_group = 8'h00;
    done("banks and blocking");
    sfc = 4'h5;
    sf = 1'b1;
    cyc(5);
    `CHK("alarm lamp", 1'b1, alm)
    `CHK("alarm relay", 1'b1, rly)
    `CHK("red one", 4'h1, red)
    `CHK("green code", 4'h5, grn)
    done("self supervision");
    finish_test();
  end
endmodule // efti_top_tb
`default_nettype wire
